// file: ladder_dac_pkg.sv
// Register map, field positions and reset values of the ladder code mapper
package ladder_dac_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] analog_control_offset     = 8'hEF;
    localparam logic [7:0] signed_sample_hold_offset = 8'hFA;
    // ------------------------------------------------------------
    // Field positions of analog_control
    // ------------------------------------------------------------
    localparam int half_swing_select_bit   = 3;
    localparam int fine_bit_low_bit        = 4;
    localparam int fine_bit_high_bit       = 5;
    localparam int analog_ctl_write_guard_bit = 7;
    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int reg_width    = 8;
    localparam int ladder_width = 10;
    localparam logic [7:0] analog_control_reset     = 8'h00;
    localparam logic [7:0] signed_sample_hold_reset = 8'h80;
    localparam logic [9:0] ladder_code_reset        = 10'h000;
endpackage

// file: ladder_map_if.sv
// Signals between the register front end and the code mapping logic
`timescale 1ns/1ps
`default_nettype none
interface ladder_map_if;
    logic [7:0] sample;
    logic       fine_bit_high;
    logic       fine_bit_low;
    logic       half_swing_select;
    logic [9:0] mapped_code;

    modport front (output sample, output fine_bit_high, output fine_bit_low,
                   output half_swing_select, input mapped_code);
    modport mapper (input sample, input fine_bit_high, input fine_bit_low,
                    input half_swing_select, output mapped_code);
endinterface
`default_nettype wire

// file: ladder_code_map.sv
// Maps signed sample and fine bits onto the ten ladder input bits
`timescale 1ns/1ps
`default_nettype none
module ladder_code_map (
    ladder_map_if.mapper link
);
    // ------------------------------------------------------------
    // Full-scale or half-scale mapping
    // ------------------------------------------------------------
    always_comb begin
        if (link.half_swing_select) begin
            // Sign extension on top, fine_bit_low ignored
            link.mapped_code = {~link.sample[7], link.sample,
                                link.fine_bit_high};
        end else begin
            link.mapped_code = {~link.sample[7], link.sample[6:0],
                                link.fine_bit_high, link.fine_bit_low};
        end
    end
endmodule
`default_nettype wire

// file: ladder_dac_code_mapper.sv
// Register front end and registered ladder code of the audio ladder converter
`timescale 1ns/1ps
`default_nettype none
module ladder_dac_code_mapper (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [7:0] address,
    input  wire logic [7:0] write_data,
    input  wire logic       write_strobe,
    input  wire logic       read_strobe,
    output logic      [7:0] read_data,
    output logic      [9:0] ladder_code
);
    // ------------------------------------------------------------
    // Registers and next values
    // ------------------------------------------------------------
    logic [6:0] analog_control;
    logic [7:0] signed_sample_hold;
    logic [6:0] next_analog_control;
    logic [7:0] next_signed_sample_hold;
    logic [7:0] next_read_data;
    logic [9:0] next_ladder_code;
    logic       ctl_write;
    logic       sample_write;

    ladder_map_if link ();

    ladder_code_map mapper (
        .link (link.mapper)
    );

    // Fields into the mapper
    assign link.sample            = signed_sample_hold;
    assign link.fine_bit_high     = analog_control[ladder_dac_pkg::fine_bit_high_bit];
    assign link.fine_bit_low      = analog_control[ladder_dac_pkg::fine_bit_low_bit];
    assign link.half_swing_select =
        analog_control[ladder_dac_pkg::half_swing_select_bit];

    // ------------------------------------------------------------
    // Address decode and next register values
    // ------------------------------------------------------------
    always_comb begin
        next_analog_control     = analog_control;
        next_signed_sample_hold = signed_sample_hold;
        next_read_data          = 8'h00;
        ctl_write    = 1'b0;
        sample_write = 1'b0;
        if (write_strobe) begin
            if (address == ladder_dac_pkg::analog_control_offset) begin
                ctl_write = 1'b1;
                // Guard bit high blocks the update of the low bits
                if (!write_data[ladder_dac_pkg::analog_ctl_write_guard_bit]) begin
                    next_analog_control = write_data[6:0];
                end
            end else if (address == ladder_dac_pkg::signed_sample_hold_offset) begin
                sample_write = 1'b1;
                next_signed_sample_hold = write_data;
            end
        end
        // Read answer registered, so it stands in the cycle after each strobe cycle
        if (read_strobe) begin
            if (address == ladder_dac_pkg::analog_control_offset) begin
                next_read_data = {1'b0, analog_control};
            end else if (address == ladder_dac_pkg::signed_sample_hold_offset) begin
                next_read_data = signed_sample_hold;
            end else begin
                next_read_data = 8'h00; // Unmapped reads as zero
            end
        end
        // Code follows registers one edge after they change
        next_ladder_code = link.mapped_code;
    end

    // ------------------------------------------------------------
    // Register stage
    // ------------------------------------------------------------
    // Reset parks the sample at 80H so the ladder idles at lowest current
    always_ff @(posedge clock) begin
        if (reset) begin
            analog_control     <= ladder_dac_pkg::analog_control_reset[6:0];
            signed_sample_hold <= ladder_dac_pkg::signed_sample_hold_reset;
            read_data          <= 8'h00;
            ladder_code        <= ladder_dac_pkg::ladder_code_reset;
        end else begin
            analog_control     <= next_analog_control;
            signed_sample_hold <= next_signed_sample_hold;
            read_data          <= next_read_data;
            ladder_code        <= next_ladder_code;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // Accepted control write, and a cycle with no write at all
    sequence ctl_write_ok_s;
        ctl_write && !write_data[7];
    endsequence

    sequence quiet_s;
        !write_strobe;
    endsequence

    // Register stores and mode steering
    sample_store_a: assert property (@(posedge clock) disable iff (reset)
        sample_write |=> signed_sample_hold == $past(write_data))
        else $error("sample register did not store write data");

    mode_select_a: assert property (@(posedge clock) disable iff (reset)
        ctl_write_ok_s ##1 quiet_s |=>
            ladder_code[0] == ($past(write_data[3], 2) ? $past(write_data[5], 2) :
                               $past(write_data[4], 2)))
        else $error("mode bit did not steer ladder bit 0");

    // Mapping one edge after the registers settle
    full_map_a: assert property (@(posedge clock) disable iff (reset)
        !link.half_swing_select |=> ladder_code ==
            {~$past(signed_sample_hold[7]), $past(signed_sample_hold[6:0]),
             $past(analog_control[5:4])})
        else $error("full-scale mapping wrong");

    half_map_a: assert property (@(posedge clock) disable iff (reset)
        link.half_swing_select |=> ladder_code ==
            {~$past(signed_sample_hold[7]), $past(signed_sample_hold),
             $past(analog_control[5])})
        else $error("half-scale mapping wrong");

    full_mid_a: assert property (@(posedge clock) disable iff (reset)
        (!link.half_swing_select && signed_sample_hold == 8'h00 &&
         analog_control[5:4] == 2'b00) |=> ladder_code == 10'h200)
        else $error("full-scale zero not at mid code");

    half_top_a: assert property (@(posedge clock) disable iff (reset)
        (link.half_swing_select && signed_sample_hold == 8'h7F &&
         analog_control[5]) |=> ladder_code == 10'h2FF)
        else $error("half-scale top code wrong");

    half_bottom_a: assert property (@(posedge clock) disable iff (reset)
        (link.half_swing_select && signed_sample_hold == 8'h80 &&
         !analog_control[5]) |=> ladder_code == 10'h100)
        else $error("half-scale bottom code wrong");

    // Parked state after an unguarded sample write
    low_power_a: assert property (@(posedge clock) disable iff (reset)
        (sample_write && write_data == 8'h80 && analog_control[5:3] == 3'b000)
            ##1 quiet_s |=> ladder_code == 10'h000)
        else $error("lowest-current code not reached");

    // Guarded writes and reset
    guard_block_a: assert property (@(posedge clock) disable iff (reset)
        (ctl_write && write_data[7]) |=> $stable(analog_control))
        else $error("guarded control write changed register");

    reset_clear_a: assert property (@(posedge clock)
        reset |=> ladder_code == 10'h000 && read_data == 8'h00)
        else $error("reset did not clear outputs");

    // Read answer stands in the cycle after the strobe, zero otherwise
    sequence sample_read_s;
        read_strobe && address == ladder_dac_pkg::signed_sample_hold_offset;
    endsequence

    sequence control_read_s;
        read_strobe && address == ladder_dac_pkg::analog_control_offset;
    endsequence

    sample_read_a: assert property (@(posedge clock) disable iff (reset)
        sample_read_s |=> read_data == $past(signed_sample_hold))
        else $error("sample read back wrong");

    control_read_a: assert property (@(posedge clock) disable iff (reset)
        control_read_s |=> read_data == {1'b0, $past(analog_control)})
        else $error("control read back wrong");

    read_idle_a: assert property (@(posedge clock) disable iff (reset)
        !read_strobe |=> read_data == 8'h00)
        else $error("read data not zero outside a read");

    // Unguarded control write lands in the register whole
    control_store_a: assert property (@(posedge clock) disable iff (reset)
        ctl_write_ok_s |=> analog_control == $past(write_data[6:0]))
        else $error("control write not stored");

    // Writes to other addresses leave both registers alone
    stray_write_a: assert property (@(posedge clock) disable iff (reset)
        (write_strobe && !ctl_write && !sample_write) |=>
            $stable(signed_sample_hold) && $stable(analog_control))
        else $error("unmapped write changed a register");

    // Reset leaves the converter in its lowest-current state
    reset_state_a: assert property (@(posedge clock)
        reset |=> signed_sample_hold == 8'h80 && analog_control == 7'h00)
        else $error("reset did not park the converter");

    // Sign bit of the code is the inverted sample sign in both modes
    sign_bit_a: assert property (@(posedge clock) disable iff (reset)
        1'b1 |=> ladder_code[9] == ~$past(signed_sample_hold[7]))
        else $error("ladder sign bit wrong");

    // Code takes a new sample on the edge after the register write
    code_update_a: assert property (@(posedge clock) disable iff (reset)
        sample_write ##1 quiet_s |=> ladder_code[9] == ~$past(write_data[7], 2))
        else $error("ladder code did not follow the sample write");

    // With no writes the code holds its value
    code_hold_a: assert property (@(posedge clock) disable iff (reset)
        quiet_s ##1 quiet_s |=> $stable(ladder_code))
        else $error("ladder code moved without a write");
endmodule
`default_nettype wire

// file: speaker_amp_model.sv
// Behavioural external amplifier driven by the ladder code
`timescale 1ns/1ps
`default_nettype none
module speaker_amp_model (
    input  wire logic          clock,
    input  wire logic   [9:0]  ladder_code,
    output logic signed [10:0] level,
    output logic               quiet
);
    // Offset-binary code to signed drive level, one cycle of lag
    always_ff @(posedge clock) begin
        level <= $signed({1'b0, ladder_code}) - 11'sh200;
        quiet <= (ladder_code == 10'h000);
    end
endmodule
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the ladder code mapper
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("CHECK FAILED %0t: %s", $time, msg); end end
module tb_top;
    // ------------------------------------------------------------
    // Signals, tables and instances
    // ------------------------------------------------------------
    logic               clock        = 1'b0;
    logic               reset        = 1'b1;
    logic        [7:0]  address      = 8'h00;
    logic        [7:0]  write_data   = 8'h00;
    logic               write_strobe = 1'b0;
    logic               read_strobe  = 1'b0;
    logic        [7:0]  read_data;
    logic        [9:0]  ladder_code;
    logic signed [10:0] amp_level;
    logic               amp_quiet;
    int                 mismatches   = 0;
    int                 n_compared   = 0;
    // Control, sample and expected code; first seven full-scale, rest half-scale
    localparam logic [7:0] ctl_tab [13] = '{8'h00, 8'h30, 8'h00, 8'h20, 8'h10, 8'h30,
                                            8'h00, 8'h08, 8'h28, 8'h18, 8'h38, 8'h28, 8'h08};
    localparam logic [7:0] smp_tab [13] = '{8'h80, 8'h80, 8'h81, 8'hFF, 8'h00, 8'h7F,
                                            8'h00, 8'h80, 8'h80, 8'h81, 8'hFF, 8'h7F, 8'h02};
    localparam logic [9:0] code_tab [13] = '{10'h000, 10'h003, 10'h004, 10'h1FE, 10'h201,
        10'h3FF, 10'h200, 10'h100, 10'h101, 10'h102, 10'h1FF, 10'h2FF, 10'h204};
    always #4 clock = ~clock;
    ladder_dac_code_mapper ladder_dac_code_mapper_inst (.clock(clock), .reset(reset),
        .address(address), .write_data(write_data), .write_strobe(write_strobe),
        .read_strobe(read_strobe), .read_data(read_data), .ladder_code(ladder_code));
    speaker_amp_model speaker_amp_model_inst (.clock(clock), .ladder_code(ladder_code),
        .level(amp_level), .quiet(amp_quiet));
    // ------------------------------------------------------------
    // Bus and comparison tasks
    // ------------------------------------------------------------
    // Write strobe stays high so writes may follow back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        address <= a;
        write_data <= d;
        write_strobe <= 1'b1;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        write_strobe <= 1'b0;
        address <= a;
        read_strobe <= 1'b1;
        @(posedge clock);
        read_strobe <= 1'b0;
        #2;
        `CHK(read_data, exp, "read data")
        @(posedge clock);
        #2;
        `CHK(read_data, 8'h00, "read data released")
        @(posedge clock);
    endtask
    // Code settles one edge after the write edge, amplifier one later
    task automatic chk(input logic [9:0] exp);
        write_strobe <= 1'b0;
        repeat (2) @(posedge clock);
        #2;
        `CHK(ladder_code, exp, "ladder code")
        `CHK(amp_level, 11'(exp) - 11'h200, "amplifier level")
        @(posedge clock);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic scn_reset;
        #2;
        `CHK(ladder_code, 10'h000, "code after reset")
        `CHK(read_data, 8'h00, "idle read data")
        @(posedge clock);
        rd(8'hFA, 8'h80);
        rd(8'hEF, 8'h00);
    endtask
    task automatic scn_map;
        for (int i = 0; i < 13; i++) begin
            wr(8'hEF, ctl_tab[i]);
            wr(8'hFA, smp_tab[i]);
            chk(code_tab[i]);
        end
    endtask
    task automatic scn_guard;
        wr(8'hEF, 8'h28);
        wr(8'hFA, 8'h00);
        wr(8'hEF, 8'hB7);
        chk(10'h201);
        rd(8'hEF, 8'h28);
        wr(8'hEF, 8'h4F);
        chk(10'h200);
        rd(8'hEF, 8'h4F);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00);
        rd(8'hFA, 8'h00);
    endtask
    task automatic scn_pdown;
        wr(8'hEF, 8'h00);
        wr(8'hFA, 8'h80);
        chk(10'h000);
        `CHK(amp_quiet, 1'b1, "amplifier quiet")
    endtask
    task automatic scn_rerst;
        wr(8'hEF, 8'h38);
        wr(8'hFA, 8'h7F);
        write_strobe <= 1'b0;
        reset <= 1'b1;
        @(posedge clock);
        reset <= 1'b0;
        #2;
        `CHK(ladder_code, 10'h000, "code after second reset")
        @(posedge clock);
        rd(8'hFA, 8'h80);
        rd(8'hEF, 8'h00);
    endtask
    task print_verdict;
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        @(posedge clock);
        scn_reset();
        scn_map();
        scn_guard();
        scn_pdown();
        scn_rerst();
        print_verdict();
    end
    // Watchdog against a hang
    initial begin
        #20000;
        mismatches++;
        print_verdict();
    end
endmodule
`default_nettype wire
